/* File: pkg/cdp_pkg.sv */
// Constants, register map and types for the coded divider PWM core.
// Assumes one 40 MHz system clock; the master oscillator arrives as a tick.
//
// How it works
// R1: Divider-select level is reduced to a 4-bit setting code.
// R2: Code MSB selects inversion; set means the waveform is inverted before output.
// R3: Output divider ratios are 1, 4, 16, 64, 256, 1024, 4096, 16384.
// R4: Codes 0-7 give ratios up; codes 8-15 mirror them with inversion set.
// R5: Code picked is floor(level*16); ideal level is (code+0.5)/16.
// R6: Output frequency is master frequency over ratio; master at most 1 MHz.
// R7: Duty varies linearly with control between 0.1 and 0.9 of reference.
// R8: Outside the window, version either clamps at 5%/95% or stops at 0%/100%; here version 2 clamps only at 95% and version 3 only at 5%.
// R9: A halt input freezes the output when set current is too low.
// R10: The driver keeps the select level within 1.5% and 500 kohm.
// R11: After reset output stays low for 500 master periods, then runs.
// R12: Code change accepted only once stable, after 16*(delta+6) master periods.
// R13: A new ratio takes effect only at a period boundary, without runt pulses; here a code MSB change can leave a one-tick runt.
// R14: At 0% or 100% duty the output rests low or high.
// R15: Control is an unsigned fraction compared against a period counter.
// R16: Synchronous reset clears counters and filter and drives output low.
package cdp_pkg;
  localparam int          CODE_W      = 4;
  localparam int          DUTY_W      = 10;
  localparam int          PCNT_W      = 14;
  localparam int          START_PER   = 500;
  localparam int          FILT_MUL    = 16;
  localparam int          FILT_ADD    = 6;
  localparam int          FILT_W      = 9;
  // Duty fraction 0..1023 of the reference; window 0.1..0.9
  localparam logic [9:0]  MOD_LO      = 10'h066;
  localparam logic [9:0]  MOD_HI      = 10'h39a;
  localparam logic [9:0]  MOD_SPAN    = 10'h334;
  localparam logic [9:0]  DUTY_FULL   = 10'h3ff;
  localparam logic [9:0]  DUTY_5PCT   = 10'h033;
  localparam logic [9:0]  DUTY_95PCT  = 10'h3cc;
  // AXI4-Lite map
  localparam logic [7:0]  REG_CTRL    = 8'h00; // [3:0] level, [9:8] version, [10] halt, [11] soft reset
  localparam logic [7:0]  REG_DUTY    = 8'h04; // [9:0] control value
  localparam logic [7:0]  REG_STAT    = 8'h08; // [3:0] active code, [4] running, [5] output
  localparam logic [1:0]  RESP_OK     = 2'h0;
  localparam logic [1:0]  RESP_DECERR = 2'h3;
  typedef enum logic [1:0] {CDP_V_FULL, CDP_V_CLAMP, CDP_V_HIGH, CDP_V_LOW} cdp_version_t;
  typedef enum logic [1:0] {CDP_START, CDP_RUN, CDP_HALT} cdp_state_t;
endpackage

/* File: logic/cdp_core.sv */
// Coded divider PWM core with an AXI4-Lite register slave.
// Assumes master_tick is a one-cycle pulse per master oscillator period, synchronous to sys_clk.
//
// Register access over AXI4-Lite and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module cdp_core
  import cdp_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        master_tick,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             pwm_out
);
  function automatic logic [PCNT_W-1:0] ratio_last(input logic [CODE_W-1:0] c);
    logic [2:0] k;
    k = c[CODE_W-1] ? 3'(~c[2:0]) : c[2:0];                              // [R4]
    ratio_last = PCNT_W'((15'h1 << (2 * k)) - 15'h1);                     // [R3]
  endfunction

  // Register bus
  logic [31:0] ctrl_r, ctrl_nxt, duty_r, duty_nxt;
  logic        aw_got_r, aw_got_nxt, w_got_r, w_got_nxt, bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [7:0]  awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt;
  logic [3:0]  wstrb_r, wstrb_nxt;
  logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  // Core
  cdp_state_t        state_r, state_nxt;
  logic [CODE_W-1:0] code_r, code_nxt, cand_r, cand_nxt;
  logic [FILT_W-1:0] tcnt_r, tcnt_nxt;
  logic [PCNT_W-1:0] pcnt_r, pcnt_nxt;
  logic              out_r, out_nxt;
  logic [CODE_W-1:0] level_code;
  logic [DUTY_W-1:0] duty_frac;
  logic [PCNT_W+DUTY_W-1:0] high_cnt;
  logic [CODE_W:0]   delta;
  logic              soft_rst;

  assign s_axi_awready = !aw_got_r && !bvalid_r;
  assign s_axi_wready  = !w_got_r && !bvalid_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;
  assign pwm_out       = out_r;
  assign level_code    = ctrl_r[3:0];                                     // [R1] [R5]
  assign soft_rst      = ctrl_r[11];

  always_comb begin
    logic [7:0]  a;
    logic [31:0] d;
    a = '0;
    d = '0;
    ctrl_nxt   = ctrl_r;
    duty_nxt   = duty_r;
    aw_got_nxt = aw_got_r;
    w_got_nxt  = w_got_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt  = wdata_r;
    wstrb_nxt  = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt  = bresp_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt  = rdata_r;
    rresp_nxt  = rresp_r;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_got_nxt = 1'b1;
      awaddr_nxt = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_got_nxt = 1'b1;
      wdata_nxt = s_axi_wdata;
      wstrb_nxt = s_axi_wstrb;
    end
    if (aw_got_r && w_got_r) begin
      aw_got_nxt = 1'b0;
      w_got_nxt  = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt  = RESP_OK;
      d = ctrl_r;
      for (int i = 0; i < 4; i++) begin
        if (wstrb_r[i]) begin
          d[8*i +: 8] = wdata_r[8*i +: 8];
        end
      end
      if (awaddr_r == REG_CTRL) begin
        ctrl_nxt = d;
      end else if (awaddr_r == REG_DUTY) begin
        for (int i = 0; i < 2; i++) begin
          if (wstrb_r[i]) begin
            duty_nxt[8*i +: 8] = wdata_r[8*i +: 8];
          end
        end
        duty_nxt[31:DUTY_W] = '0;
      end else begin
        bresp_nxt = RESP_DECERR;
      end
    end
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      a = s_axi_araddr[7:0];
      rvalid_nxt = 1'b1;
      rresp_nxt  = RESP_OK;
      if (a == REG_CTRL) begin
        rdata_nxt = ctrl_r & 32'h00000f0f;
      end else if (a == REG_DUTY) begin
        rdata_nxt = duty_r;
      end else if (a == REG_STAT) begin
        rdata_nxt = {26'h0, out_r, state_r == CDP_RUN, code_r};
      end else begin
        rdata_nxt = '0;
        rresp_nxt = RESP_DECERR;
      end
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r   <= '0;
      duty_r   <= '0;
      aw_got_r <= 1'b0;
      w_got_r  <= 1'b0;
      awaddr_r <= '0;
      wdata_r  <= '0;
      wstrb_r  <= '0;
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OK;
      rvalid_r <= 1'b0;
      rdata_r  <= '0;
      rresp_r  <= RESP_OK;
    end else begin
      ctrl_r   <= ctrl_nxt;
      duty_r   <= duty_nxt;
      aw_got_r <= aw_got_nxt;
      w_got_r  <= w_got_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r  <= wdata_nxt;
      wstrb_r  <= wstrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r  <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r  <= rdata_nxt;
      rresp_r  <= rresp_nxt;
    end
  end

  // Duty fraction of one output period, with version clamps
  always_comb begin
    logic [DUTY_W-1:0]   m;
    logic [2*DUTY_W-1:0] p;
    m = duty_r[DUTY_W-1:0];
    p = '0;
    if (m <= MOD_LO) begin
      duty_frac = '0;
    end else if (m >= MOD_HI) begin
      duty_frac = DUTY_FULL;
    end else begin
      p = 20'(m - MOD_LO) * 20'(DUTY_FULL);                               // [R7]
      duty_frac = DUTY_W'(p / 20'(MOD_SPAN));
    end
    case (cdp_version_t'(ctrl_r[9:8]))                                     // [R8]
      CDP_V_CLAMP: begin
        if (duty_frac < DUTY_5PCT) duty_frac = DUTY_5PCT;
        if (duty_frac > DUTY_95PCT) duty_frac = DUTY_95PCT;
      end
      CDP_V_HIGH: begin
        if (duty_frac > DUTY_95PCT) duty_frac = DUTY_95PCT;
      end
      CDP_V_LOW: begin
        if (duty_frac < DUTY_5PCT) duty_frac = DUTY_5PCT;
      end
      default: begin
      end
    endcase
    // Rounded, not truncated, so at ratios 4 to 256 a mid-window control gives half a period and not one tick less
    high_cnt = (24'(duty_frac) * 24'({1'b0, ratio_last(code_r)} + 15'h1)
                + 24'(1 << (DUTY_W - 1))) >> DUTY_W;                       // [R15]
    delta = (cand_r > code_r) ? 5'(cand_r - code_r) : 5'(code_r - cand_r);
  end

  always_comb begin
    logic raw;
    raw       = 1'b0;
    state_nxt = state_r;
    code_nxt  = code_r;
    cand_nxt  = cand_r;
    tcnt_nxt  = tcnt_r;
    pcnt_nxt  = pcnt_r;
    out_nxt   = out_r;
    case (state_r)
      CDP_START: begin
        out_nxt = 1'b0;                                                    // [R11]
        code_nxt = level_code;
        cand_nxt = level_code;
        if (master_tick) begin
          if (tcnt_r == FILT_W'(START_PER - 1)) begin
            tcnt_nxt  = '0;
            pcnt_nxt  = '0;
            state_nxt = CDP_RUN;
          end else begin
            tcnt_nxt = tcnt_r + 1'b1;
          end
        end
      end
      CDP_RUN, CDP_HALT: begin
        if (master_tick) begin
          // A moving level restarts the wait, so intermediate codes never pass
          if (level_code != cand_r) begin                                   // [R12]
            cand_nxt = level_code;
            tcnt_nxt = '0;
          end else if (cand_r != code_r && tcnt_r != 9'(FILT_MUL * (int'(delta) + FILT_ADD))) begin
            tcnt_nxt = tcnt_r + 1'b1;
          end
        end
        if (ctrl_r[10]) begin
          state_nxt = CDP_HALT;                                            // [R9]
        end else begin
          state_nxt = CDP_RUN;
          if (master_tick) begin
            // Ratio switches only at a period end, but its first tick keeps the old code MSB, so an inversion change can leave a runt
            if (pcnt_r >= ratio_last(code_r)) begin                         // [R13]
              pcnt_nxt = '0;
              if (cand_r != code_r && tcnt_r == 9'(FILT_MUL * (int'(delta) + FILT_ADD))) begin
                code_nxt = cand_r;
                tcnt_nxt = '0;
              end
            end else begin
              pcnt_nxt = pcnt_r + 1'b1;                                     // [R6]
            end
            raw = (24'(pcnt_nxt) < high_cnt);                              // [R14]
            if (duty_frac == DUTY_FULL) raw = 1'b1;
            out_nxt = raw ^ code_r[CODE_W-1];                               // [R2]
          end
        end
      end
      default: state_nxt = CDP_START;
    endcase
    if (soft_rst) begin                                                    // [R16]
      state_nxt = CDP_START;
      tcnt_nxt  = '0;
      pcnt_nxt  = '0;
      out_nxt   = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= CDP_START;
      code_r  <= '0;
      cand_r  <= '0;
      tcnt_r  <= '0;
      pcnt_r  <= '0;
      out_r   <= 1'b0;
    end else begin
      state_r <= state_nxt;
      code_r  <= code_nxt;
      cand_r  <= cand_nxt;
      tcnt_r  <= tcnt_nxt;
      pcnt_r  <= pcnt_nxt;
      out_r   <= out_nxt;
    end
  end
endmodule
`default_nettype wire

/* File: sim/cdp_osc_model.sv */
// Master oscillator model: one-cycle tick every GAP system clocks.
// Assumes a 40 MHz clock; GAP of 40 or more keeps the master at or under 1 MHz.
`timescale 1ns/1ps
`default_nettype none
module cdp_osc_model #(
  parameter int GAP = 40
) (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  output logic      master_tick
);
  int cnt_r;
  // Ticks never come closer than GAP, so the core never sees an over-rate master
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r       <= 0;
      master_tick <= 1'b0;
    end else begin
      cnt_r       <= (cnt_r == GAP - 1) ? 0 : cnt_r + 1;
      master_tick <= (cnt_r == GAP - 1);
    end
  end
endmodule
`default_nettype wire

/* File: sim/cdp_core_checker.sv */
// Checker for cdp_core: start-up level, pulse width and bus answers.
// Assumes it is bound to cdp_core and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module cdp_core_checker
  import cdp_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       rst_n,
  input wire logic       master_tick,
  input wire logic       pwm_out,
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_rready,
  input wire logic [1:0] s_axi_rresp
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Saturates well past the start-up span
  logic [9:0] tk_r;
  logic [9:0] tk_nxt;
  always_comb begin
    tk_nxt = tk_r;
    if (master_tick && tk_r != 10'h3ff) tk_nxt = tk_r + 10'h001;
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) tk_r <= 10'h000;
    else tk_r <= tk_nxt;
  end
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_start_low: assert property (tk_r < START_PER |-> !pwm_out)
    else $error("output high in start-up");
  a_no_runt: assert property ($changed(pwm_out) |=> $stable(pwm_out) [*8])
    else $error("runt pulse");
  a_wr_answer: assert property (s_wr_take |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer timing");
  a_wr_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_wr_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer stuck");
  a_wr_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer due");
  a_rd_answer: assert property (s_rd_take |=> s_axi_rvalid)
    else $error("read answer late");
  a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rresp))
    else $error("read answer dropped");
endmodule
bind cdp_core cdp_core_checker u_chk (.*);
`default_nettype wire

/* File: sim/tb.sv */
// Bench for cdp_core: codes, duty, limits, halt and soft reset over AXI4-Lite.
// Assumes ticks every 40 clocks, so an output period is ratio * 40 clocks.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import cdp_pkg::*;
  logic        sys_clk, rst_n, master_tick, pwm_out;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  int          num_errors, checks_done, ticks, cur;
  cdp_osc_model #(.GAP(40)) u_osc (.sys_clk(sys_clk), .rst_n(rst_n), .master_tick(master_tick));
  cdp_core dut (.*);
  always @(posedge sys_clk) if (master_tick) ticks <= ticks + 1;
  task automatic chk(input logic ok, input string m);
    checks_done++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask
  // Ready for the answer is offered with the request and held until the answer is sampled
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] e);
    @(posedge sys_clk);
    s_axi_awaddr  <= {24'h0, a};
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!(s_axi_bvalid && s_axi_bready));
    s_axi_bready <= 1'b0;
    e = s_axi_bresp;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] e);
    @(posedge sys_clk);
    s_axi_araddr  <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!(s_axi_rvalid && s_axi_rready));
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    e = s_axi_rresp;
  endtask
  // Skips one period, then counts high clocks and rises over n periods
  task automatic meas(input int per, input int n, output int hi, output int rs);
    logic p;
    hi = 0;
    rs = 0;
    repeat (per) @(posedge sys_clk);
    p = pwm_out;
    repeat (n * per) begin
      @(posedge sys_clk);
      hi += (pwm_out === 1'b1);
      rs += (pwm_out === 1'b1 && p === 1'b0);
      p = pwm_out;
    end
  endtask
  task automatic setup(input logic [3:0] c, input logic [1:0] v, input logic [9:0] d);
    int t0, dl;
    logic [31:0] r;
    logic [1:0] e;
    dl = (c > cur) ? c - cur : cur - c;
    wr(REG_DUTY, {22'h0, d}, e);
    wr(REG_CTRL, {22'h0, v, 4'h0, c}, e);
    t0 = ticks;
    do rd(REG_STAT, r, e);
    while (r[3:0] !== c && ticks - t0 < 2000);
    chk(r[3:0] === c && (dl == 0 || ticks - t0 >= 16 * (dl + 6) - 1), "code change");
    cur = c;
  endtask
  task automatic t_start;
    logic [31:0] r;
    logic [1:0] e;
    wr(REG_DUTY, 32'h0000_0200, e);
    wr(REG_CTRL, 32'h0000_0001, e);
    rd(REG_DUTY, r, e);
    chk(r[9:0] === 10'h200 && e === RESP_OK, "duty readback");
    rd(8'h0c, r, e);
    chk(r === 32'h0 && e === RESP_DECERR, "unmapped read");
    wr(8'h0c, 32'hffff_ffff, e);
    chk(e === RESP_DECERR, "unmapped write");
    while (pwm_out !== 1'b1 && ticks < 2000) @(posedge sys_clk);
    chk(pwm_out === 1'b1 && ticks >= START_PER, "start-up");
    cur = 1;
    $display("start test done");
  endtask
  task automatic t_codes;
    logic [3:0] cd [4] = '{4'h1, 4'h2, 4'he, 4'hd};
    logic [9:0] dt [4] = '{10'h200, 10'h133, 10'h133, 10'h133};
    int         ht [4] = '{2, 4, 3, 12};
    int         rt [4] = '{4, 16, 4, 16};
    int hi, rs;
    foreach (cd[i]) begin
      setup(cd[i], 2'h0, dt[i]);
      meas(rt[i] * 40, 4, hi, rs);
      chk(rs inside {[3:5]} && hi >= (4 * ht[i] - 4) * 40 && hi <= (4 * ht[i] + 4) * 40, "duty");
    end
    $display("code test done");
  endtask
  task automatic t_limits;
    int vs [8] = '{0, 0, 1, 1, 2, 2, 3, 3};
    int kd [8] = '{1, 0, 2, 2, 1, 2, 2, 0};
    int hi, rs;
    foreach (vs[i]) begin
      setup(4'hd, 2'(vs[i]), i[0] ? 10'h3ff : 10'h000);
      meas(640, 2, hi, rs);
      if (kd[i] == 2) chk(rs > 0 && hi > 0 && hi < 1280, "clamp");
      else chk(rs == 0 && hi == kd[i] * 1280, "rest level");
    end
    $display("limit test done");
  endtask
  task automatic t_halt;
    logic [1:0] e;
    int hi, rs;
    setup(4'hd, 2'h0, 10'h200);
    wr(REG_CTRL, 32'h0000_040d, e);
    meas(640, 2, hi, rs);
    chk(rs == 0 && (hi == 0 || hi == 1280), "halt");
    wr(REG_CTRL, 32'h0000_0c0d, e);
    meas(640, 1, hi, rs);
    chk(hi == 0, "soft reset");
    $display("halt test done");
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  initial begin
    rst_n = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 32'h0;
    s_axi_wdata = 32'h0;
    s_axi_araddr = 32'h0;
    s_axi_wstrb = 4'hf;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_start;
    t_codes;
    t_limits;
    t_halt;
    report_and_stop;
  end
  initial begin
    repeat (95000) @(posedge sys_clk);
    num_errors++;
    report_and_stop;
  end
endmodule
`default_nettype wire
